// ===== verilog/lhfr_consts.svh
// constants of the load handshake and fault retry controller
`ifndef LHFR_CONSTS_SVH
`define LHFR_CONSTS_SVH

// clock rate in kHz (25 MHz)
`define LHFR_CLK_KHZ 25000
// minimum retry delay in microseconds
`define LHFR_MIN_DLY_US 1000
// minimum retry delay in clock cycles, derived from the time
`define LHFR_MIN_DLY_CYC ((`LHFR_MIN_DLY_US * `LHFR_CLK_KHZ) / 1000)
// oscillator periods in one capacitor-set retry delay
`define LHFR_OSC_PER_DLY 16'd128
// quiet retry delay periods that reset the retry count
`define LHFR_QUIET_PERIODS 3'd7
// quantization levels of the retry count
`define LHFR_CNT_LVL0 11'h004
`define LHFR_CNT_LVL1 11'h010
`define LHFR_CNT_LVL2 11'h040
`define LHFR_CNT_LVL3 11'h100
`define LHFR_CNT_LVL4 11'h400
// retry count for an open retry count pin
`define LHFR_CNT_OPEN 11'h004
// saturation value of the retry counter
`define LHFR_CNT_MAX 11'h7FF
// width of the handshake timer
`define LHFR_HS_W 24

`endif

// ===== verilog/lhfr_pkg.sv
// types and helper functions of the load handshake and fault retry controller
`include "lhfr_consts.svh"

package lhfr_pkg;

    // main sequencer states, gray coded along the usual path
    typedef enum logic [2:0] {
        LHFR_DISABLED = 3'h0,
        LHFR_STARTUP = 3'h1,
        LHFR_ON = 3'h3,
        LHFR_FAULT = 3'h2,
        LHFR_HS_OFF = 3'h7
    } lhfr_state_t;

    // rounds a computed retry count up to the next supported level, 1024 at most
    function automatic logic [10:0] lhfr_quantize(input logic [15:0] n);
        logic [10:0] r;
        r = `LHFR_CNT_LVL4;
        if (n <= 16'(`LHFR_CNT_LVL0)) begin
            r = `LHFR_CNT_LVL0;
        end else if (n <= 16'(`LHFR_CNT_LVL1)) begin
            r = `LHFR_CNT_LVL1;
        end else if (n <= 16'(`LHFR_CNT_LVL2)) begin
            r = `LHFR_CNT_LVL2;
        end else if (n <= 16'(`LHFR_CNT_LVL3)) begin
            r = `LHFR_CNT_LVL3;
        end
        return r;
    endfunction

endpackage

// ===== verilog/lhfr_retry_if.sv
// signals between the sequencer and the auto-retry engine
`timescale 1ns/1ps
`default_nettype none

interface lhfr_retry_if;
    logic fault_pulse;   // fault latch being set
    logic latched;       // fault latch state
    logic ext_reset;     // supply or enable dropped
    logic allowed;       // auto-retry enabled by strap
    logic dly_cap;       // capacitor-set delay selected
    logic unlimited;     // indefinite retries
    logic [10:0] limit;  // finite retry count
    logic osc_tick;      // one retry oscillator period
    logic clear_pulse;   // auto-retry clears the latch
    logic exhausted;     // finite count used up
    logic [10:0] count;  // retries taken so far

    modport ctrl (output fault_pulse, latched, ext_reset, allowed, dly_cap,
        unlimited, limit, osc_tick, input clear_pulse, exhausted, count);
    modport retry (input fault_pulse, latched, ext_reset, allowed, dly_cap,
        unlimited, limit, osc_tick, output clear_pulse, exhausted, count);
endinterface

`default_nettype wire

// ===== verilog/lhfr_retry.sv
// auto-retry engine: retry delay, retry count and quiet-time count reset
`timescale 1ns/1ps
`default_nettype none
`include "lhfr_consts.svh"

module lhfr_retry #(
    parameter logic [15:0] MIN_DLY_CYC = 16'(`LHFR_MIN_DLY_CYC)
) (
    // clock and synchronised reset
    input wire logic clk,
    input wire logic rst_n,
    // link to the sequencer
    lhfr_retry_if.retry rif
);
    import lhfr_pkg::*;

    logic [15:0] pre_q, pre_d;
    logic [2:0] quiet_q, quiet_d;
    logic [10:0] cnt_q, cnt_d;
    logic period_done;

    // -------------------------------------------------------------
    // delay period timer and counters
    // -------------------------------------------------------------
    always_comb begin
        pre_d = pre_q;
        quiet_d = quiet_q;
        cnt_d = cnt_q;
        period_done = 1'b0;
        // one delay is 128 oscillator periods or the fixed minimum
        if (rif.dly_cap) begin
            if (rif.osc_tick) begin
                if (pre_q >= `LHFR_OSC_PER_DLY - 16'h0001) begin
                    pre_d = 16'h0000;
                    period_done = 1'b1;
                end else begin
                    pre_d = pre_q + 16'h0001;
                end
            end
        end else if (pre_q >= MIN_DLY_CYC - 16'h0001) begin
            pre_d = 16'h0000;
            period_done = 1'b1;
        end else begin
            pre_d = pre_q + 16'h0001;
        end
        // count up once per quiet period, reset count after seven
        if (period_done && !rif.latched && cnt_q != 11'h000) begin
            if (quiet_q == `LHFR_QUIET_PERIODS - 3'h1) begin
                quiet_d = 3'h0;
                cnt_d = 11'h000;
            end else begin
                quiet_d = quiet_q + 3'h1;
            end
        end
        // each fault shutdown counts one, holding at the saturation value, and restarts the delay
        if (rif.fault_pulse) begin
            pre_d = 16'h0000;
            quiet_d = 3'h0;
            if (cnt_q != `LHFR_CNT_MAX) begin
                cnt_d = cnt_q + 11'h001;
            end
        end
        // an external reset starts a fresh sequence
        if (rif.ext_reset) begin
            cnt_d = 11'h000;
            quiet_d = 3'h0;
        end
    end

    // counter registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 16'h0000;
            quiet_q <= 3'h0;
            cnt_q <= 11'h000;
        end else begin
            pre_q <= pre_d;
            quiet_q <= quiet_d;
            cnt_q <= cnt_d;
        end
    end

    // latch clears after one delay while retries remain
    assign rif.exhausted = !rif.unlimited && (cnt_q > rif.limit);
    assign rif.clear_pulse = rif.latched && rif.allowed && !rif.exhausted &&
        period_done && !rif.fault_pulse;
    assign rif.count = cnt_q;

endmodule

`default_nettype wire

// ===== verilog/lhfr_top.sv
// load handshake timer, fault latch and strap-selected auto-retry control
`timescale 1ns/1ps
`default_nettype none
`include "lhfr_consts.svh"

module lhfr_top #(
    parameter logic [15:0] MIN_DLY_CYC = 16'(`LHFR_MIN_DLY_CYC)
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // supply and enable comparators
    input wire logic supply_above_falling,
    input wire logic supply_above_rising,
    input wire logic enable_above_shutdown,
    input wire logic enable_above_rising,
    // power stage
    input wire logic startup_done,
    // load handshake
    input wire logic load_handshake_line,
    input wire logic [`LHFR_HS_W-1:0] hs_timeout_cycles,
    // internal fault sources
    input wire logic temp_above_tsd,
    input wire logic temp_above_release,
    input wire logic breaker_trip,
    input wire logic blank_timer_pin_short,
    input wire logic current_limit_pin_short,
    // retry straps
    input wire logic retry_delay_pin_short,
    input wire logic retry_delay_pin_cap,
    input wire logic retry_count_pin_short,
    input wire logic retry_count_pin_cap,
    input wire logic [15:0] retry_count_measure,
    input wire logic retry_osc,
    // status and control outputs
    output logic switch_on,
    output logic power_good_flag,
    output logic handshake_fault,
    output logic fault_latched,
    output logic latched_off,
    output logic otp_active,
    output logic [10:0] retry_count,
    output var lhfr_pkg::lhfr_state_t state
);
    import lhfr_pkg::*;

    localparam int SW = 31;

    // -------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------
    logic rst_s1_q, rst_n;

    // two flip-flops release the asynchronous reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    logic [SW-1:0] raw, sync1_q, sync2_q;
    logic osc_prev_q, osc_s1_q, osc_s2_q;

    assign raw = {supply_above_falling, supply_above_rising,
        enable_above_shutdown, enable_above_rising, startup_done,
        load_handshake_line, temp_above_tsd, temp_above_release,
        breaker_trip, blank_timer_pin_short, current_limit_pin_short,
        retry_delay_pin_short, retry_delay_pin_cap, retry_count_pin_short,
        retry_count_pin_cap, retry_count_measure};

    // two flip-flops on every pin input, plus the oscillator history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            osc_prev_q <= 1'b0;
        end else begin
            sync1_q <= {raw[SW-1:16], raw[15:0]};
            sync2_q <= sync1_q;
            osc_prev_q <= osc_s2_q;
        end
    end

    // separate two-stage synchroniser for the retry oscillator
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
        end else begin
            osc_s1_q <= retry_osc;
            osc_s2_q <= osc_s1_q;
        end
    end

    logic sup_fall, sup_rise, en_sd, en_rise, gate_full, hs_high;
    logic t_hot, t_warm, cb_trip, tmr_short, lim_short;
    logic rd_short, rd_cap, rc_short, rc_cap;
    logic [15:0] rc_meas;

    assign sup_fall = sync2_q[30];
    assign sup_rise = sync2_q[29];
    assign en_sd = sync2_q[28];
    assign en_rise = sync2_q[27];
    assign gate_full = sync2_q[26];
    assign hs_high = sync2_q[25]; // high = load released the line
    assign t_hot = sync2_q[24];
    assign t_warm = sync2_q[23];
    assign cb_trip = sync2_q[22];
    assign tmr_short = sync2_q[21];
    assign lim_short = sync2_q[20];
    assign rd_short = sync2_q[19];
    assign rd_cap = sync2_q[18];
    assign rc_short = sync2_q[17];
    assign rc_cap = sync2_q[16];
    assign rc_meas = sync2_q[15:0];

    // -------------------------------------------------------------
    // retry engine link
    // -------------------------------------------------------------
    lhfr_retry_if rif();

    lhfr_retry #(
        .MIN_DLY_CYC(MIN_DLY_CYC)
    ) u_retry (
        .clk(clk),
        .rst_n(rst_n),
        .rif(rif)
    );

    // -------------------------------------------------------------
    // supply, enable and thermal hysteresis
    // -------------------------------------------------------------
    logic sup_ok_q, sup_ok_d, en_ok_q, en_ok_d, otp_q, otp_d;
    logic enabled;

    always_comb begin
        sup_ok_d = sup_ok_q;
        en_ok_d = en_ok_q;
        otp_d = otp_q;
        // supply valid between falling and rising levels
        if (!sup_fall) begin
            sup_ok_d = 1'b0;
        end else if (sup_rise) begin
            sup_ok_d = 1'b1;
        end
        // enable valid between shutdown and rising levels
        if (!en_sd) begin
            en_ok_d = 1'b0;
        end else if (en_rise) begin
            en_ok_d = 1'b1;
        end
        // hot die holds the output off until below release level
        if (t_hot) begin
            otp_d = 1'b1;
        end else if (!t_warm) begin
            otp_d = 1'b0;
        end
    end

    // hysteresis registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sup_ok_q <= 1'b0;
            en_ok_q <= 1'b0;
            otp_q <= 1'b0;
        end else begin
            sup_ok_q <= sup_ok_d;
            en_ok_q <= en_ok_d;
            otp_q <= otp_d;
        end
    end

    assign enabled = sup_ok_q && en_ok_q;

    // -------------------------------------------------------------
    // fault latch
    // -------------------------------------------------------------
    logic latch_q, latch_d, fault_src;

    // internal shutdown sources
    assign fault_src = enabled &&
        (t_hot || cb_trip || tmr_short || lim_short);

    always_comb begin
        latch_d = latch_q;
        // a new fault wins over any clear in the same cycle
        if (fault_src) begin
            latch_d = 1'b1;
        end else if (!enabled) begin
            latch_d = 1'b0;
        end else if (rif.clear_pulse) begin
            latch_d = 1'b0;
        end
    end

    // -------------------------------------------------------------
    // strap decode for the retry engine
    // -------------------------------------------------------------
    assign rif.fault_pulse = fault_src && !latch_q;
    assign rif.latched = latch_q;
    assign rif.ext_reset = !enabled;
    assign rif.osc_tick = osc_s2_q && !osc_prev_q;
    assign rif.allowed = !rd_short;
    assign rif.dly_cap = rd_cap && !rd_short;
    // open delay pin falls back to the minimum delay
    assign rif.unlimited = rc_short;
    // open count pin gives four, capacitor gives quantized count
    assign rif.limit = (rc_cap && !rc_short) ? lhfr_quantize(rc_meas) :
        `LHFR_CNT_OPEN;

    // -------------------------------------------------------------
    // handshake timer
    // -------------------------------------------------------------
    lhfr_state_t state_q, state_d;
    logic [`LHFR_HS_W-1:0] hs_cnt_q, hs_cnt_d;
    logic hs_expire, hs_flt_q, hs_flt_d;

    // timer charges only while powered and line released
    always_comb begin
        hs_cnt_d = '0;
        if (state_q == LHFR_ON && hs_high) begin
            hs_cnt_d = hs_cnt_q + `LHFR_HS_W'(1);
            if (hs_expire) begin
                hs_cnt_d = hs_cnt_q;
            end
        end
    end

    // threshold reached with the line still high
    assign hs_expire = state_q == LHFR_ON && hs_high &&
        hs_cnt_q >= hs_timeout_cycles;

    always_comb begin
        hs_flt_d = hs_flt_q;
        if (hs_expire) begin
            hs_flt_d = 1'b1;
        end else if (!enabled || !hs_high) begin
            hs_flt_d = 1'b0;
        end
    end

    // -------------------------------------------------------------
    // power sequencer
    // -------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            LHFR_DISABLED: begin
                // enable low keeps everything off
                if (enabled && !latch_q && !otp_q) begin
                    state_d = LHFR_STARTUP;
                end
            end
            LHFR_STARTUP: begin
                if (!enabled) begin
                    state_d = LHFR_DISABLED;
                end else if (latch_q) begin
                    state_d = LHFR_FAULT;
                end else if (gate_full) begin
                    state_d = LHFR_ON;
                end
            end
            LHFR_ON: begin
                if (!enabled) begin
                    state_d = LHFR_DISABLED;
                end else if (latch_q) begin
                    state_d = LHFR_FAULT;
                end else if (hs_expire) begin
                    state_d = LHFR_HS_OFF;
                end
            end
            LHFR_FAULT: begin
                // leave when disabled, or when cleared and cool
                if (!enabled) begin
                    state_d = LHFR_DISABLED;
                end else if (!latch_q && !otp_q) begin
                    state_d = LHFR_STARTUP;
                end
            end
            LHFR_HS_OFF: begin
                if (!enabled) begin
                    state_d = LHFR_DISABLED;
                end else if (latch_q) begin
                    state_d = LHFR_FAULT;
                end else if (!hs_high) begin
                    state_d = LHFR_STARTUP;
                end
            end
            default: begin
                state_d = LHFR_DISABLED;
            end
        endcase
    end

    // -------------------------------------------------------------
    // state and output registers
    // -------------------------------------------------------------
    logic sw_d, pg_d, lo_d;

    always_comb begin
        sw_d = (state_d == LHFR_STARTUP || state_d == LHFR_ON) &&
            !latch_d;
        pg_d = state_d == LHFR_ON && !latch_d;
        lo_d = latch_d && (rd_short || rif.exhausted);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= LHFR_DISABLED;
            latch_q <= 1'b0;
            hs_cnt_q <= '0;
            hs_flt_q <= 1'b0;
            switch_on <= 1'b0;
            power_good_flag <= 1'b0;
            latched_off <= 1'b0;
            retry_count <= 11'h000;
        end else begin
            state_q <= state_d;
            latch_q <= latch_d;
            hs_cnt_q <= hs_cnt_d;
            hs_flt_q <= hs_flt_d;
            switch_on <= sw_d;
            power_good_flag <= pg_d;
            latched_off <= lo_d;
            retry_count <= rif.count;
        end
    end

    // status views of internal flops
    assign handshake_fault = hs_flt_q;
    assign fault_latched = latch_q;
    assign otp_active = otp_q;
    assign state = state_q;

endmodule

`default_nettype wire

// ===== testbench/lhfr_load_model.sv
// downstream load or plug-in module on the handshake pin
`timescale 1ns/1ps
`default_nettype none

module lhfr_load_model (
    // bench commands
    input wire logic present,
    input wire logic tied_low,
    // handshake pin
    output wire logic load_handshake_line
);
    // absent load leaves the pin to the pull-up, so it reads high
    assign load_handshake_line = ~(present | tied_low);
endmodule

`default_nettype wire

// ===== testbench/lhfr_top_asserts.sv
// port assertions of the handshake and fault retry controller
`timescale 1ns/1ps
`default_nettype none

module lhfr_top_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins
    input wire logic enable_above_shutdown,
    input wire logic supply_above_falling,
    input wire logic breaker_trip,
    input wire logic retry_delay_pin_short,
    input wire logic retry_count_pin_short,
    input wire logic retry_count_pin_cap,
    // outputs
    input wire logic switch_on,
    input wire logic power_good_flag,
    input wire logic handshake_fault,
    input wire logic fault_latched,
    input wire logic latched_off,
    input wire logic otp_active,
    input wire logic [10:0] retry_count,
    input wire lhfr_pkg::lhfr_state_t state
);
    import lhfr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // trip seen while the output is on
    sequence trip_on_s;
        (state == LHFR_ON && breaker_trip) [*2];
    endsequence
    // latch holds through a minimum span
    sequence hold_s;
        fault_latched [*8];
    endsequence
    pg_needs_sw_a: assert property (power_good_flag |-> switch_on)
        else $error("power good without switch on");
    hs_fault_off_a: assert property (handshake_fault |->
        !switch_on && !power_good_flag)
        else $error("output on during handshake fault");
    trip_latch_a: assert property (trip_on_s |-> ##[0:4] fault_latched)
        else $error("breaker trip not latched");
    latch_off_a: assert property (fault_latched |-> !switch_on)
        else $error("output on while latched");
    en_clear_a: assert property ($fell(enable_above_shutdown) |->
        ##[1:5] !fault_latched)
        else $error("enable drop did not clear latch");
    min_delay_a: assert property ($rose(fault_latched) |-> hold_s)
        else $error("retry before minimum delay");
    no_retry_a: assert property (fault_latched && retry_delay_pin_short &&
        enable_above_shutdown && supply_above_falling |=> fault_latched)
        else $error("retry with delay pin shorted");
    four_limit_a: assert property (!retry_count_pin_short &&
        !retry_count_pin_cap |-> retry_count <= 11'h005)
        else $error("open count pin exceeded four retries");
    otp_hold_a: assert property (otp_active |-> !switch_on)
        else $error("output on during thermal hold");
    limit_hold_a: assert property (latched_off |-> fault_latched)
        else $error("latched off without latch");
    dis_off_a: assert property (!enable_above_shutdown [*5] |-> !switch_on)
        else $error("output on while disabled");
endmodule

bind lhfr_top lhfr_top_asserts u_asserts (.*);

`default_nettype wire

// ===== testbench/lhfr_top_tb.sv
// self-checking bench of the handshake and fault retry controller
`timescale 1ns/1ps
`default_nettype none
`include "lhfr_consts.svh"

module lhfr_top_tb;
    import lhfr_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk, resetn, supply_above_falling, supply_above_rising;
    logic enable_above_shutdown, enable_above_rising, startup_done;
    logic load_handshake_line, temp_above_tsd, temp_above_release;
    logic breaker_trip, blank_timer_pin_short, current_limit_pin_short;
    logic retry_delay_pin_short, retry_delay_pin_cap, retry_osc;
    logic retry_count_pin_short, retry_count_pin_cap, present, tied_low;
    logic [`LHFR_HS_W-1:0] hs_timeout_cycles;
    logic [15:0] retry_count_measure;
    logic switch_on, power_good_flag, handshake_fault, fault_latched;
    logic latched_off, otp_active;
    logic [10:0] retry_count;
    lhfr_state_t state;
    int err_count, tests_run;

    lhfr_top #(.MIN_DLY_CYC(16'h0010)) DUT (.*);
    lhfr_load_model u_load (.present(present), .tied_low(tied_low),
        .load_handshake_line(load_handshake_line));

    // clock and a retry oscillator of two clocks a period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        #1;
        retry_osc = (retry_osc !== 1'b1);
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_st(input lhfr_state_t s, input int n);
        for (int i = 0; i < n && state !== s; i++) step(1);
    endtask
    task automatic wait_latch(input logic v, input int n, output int c);
        for (c = 0; c < n && fault_latched !== v; c++) step(1);
    endtask
    task automatic power_up();
        {enable_above_shutdown, enable_above_rising} = 2'h3;
        wait_st(LHFR_STARTUP, 10);
        startup_done = 1'b1;
        wait_st(LHFR_ON, 10);
        chk(state, LHFR_ON);
    endtask
    task automatic power_down();
        {enable_above_shutdown, enable_above_rising, startup_done} = 3'h0;
        step(8);
    endtask
    task automatic fire(input int k);
        {breaker_trip, blank_timer_pin_short, current_limit_pin_short} =
            3'h1 << k;
        step(4);
        {breaker_trip, blank_timer_pin_short, current_limit_pin_short} = 3'h0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_handshake();
        present = 1'b0;
        power_up();
        chk(power_good_flag, 1'b1);
        wait_st(LHFR_HS_OFF, 80);
        chk({handshake_fault, switch_on}, 2'h2);
        present = 1'b1;
        wait_st(LHFR_ON, 20);
        chk(switch_on, 1'b1);
        step(80);
        chk(state, LHFR_ON);
        present = 1'b0;
        wait_st(LHFR_HS_OFF, 80);
        chk(handshake_fault, 1'b1);
        {supply_above_falling, supply_above_rising} = 2'h0;
        step(6);
        {supply_above_falling, supply_above_rising} = 2'h3;
        wait_st(LHFR_ON, 20);
        chk({handshake_fault, switch_on}, 2'h1);
        power_down();
        present = 1'b1;
    endtask
    task automatic t_tied();
        {present, tied_low} = 2'h1;
        power_up();
        step(80);
        chk({state, handshake_fault}, 4'h6);
        power_down();
        {present, tied_low} = 2'h2;
    endtask
    task automatic t_latch();
        retry_delay_pin_short = 1'b1;
        power_up();
        fire(0);
        step(60);
        chk({fault_latched, latched_off, switch_on}, 3'h6);
        power_down();
        chk({fault_latched, switch_on}, 2'h0);
        retry_delay_pin_short = 1'b0;
    endtask
    task automatic t_retry(input int lim, input int n, input int d);
        int c;
        power_up();
        for (int i = 1; i <= n; i++) begin
            wait_st(LHFR_ON, 20);
            fire(i % 3);
            step(2);
            chk(retry_count, 16'(i));
            wait_latch(1'b0, d + 10, c);
            if (i <= lim) begin
                chk(c >= d - 8 && c <= d + 2, 1'b1);
            end else begin
                chk({fault_latched, latched_off}, 2'h3);
            end
        end
        power_down();
    endtask
    task automatic t_quiet();
        power_up();
        fire(0);
        step(90);
        chk(retry_count, 16'h0001);
        step(50);
        chk(retry_count, 16'h0000);
        power_down();
    endtask
    task automatic t_otp();
        power_up();
        {temp_above_tsd, temp_above_release} = 2'h3;
        step(4);
        temp_above_tsd = 1'b0;
        step(40);
        chk({otp_active, switch_on}, 2'h2);
        temp_above_release = 1'b0;
        wait_st(LHFR_ON, 30);
        chk(switch_on, 1'b1);
        power_down();
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run length
    initial begin
        #1000000;
        err_count++;
        give_verdict();
    end
    // main sequence
    initial begin
        {resetn, startup_done, temp_above_tsd, temp_above_release} = 4'h0;
        {enable_above_shutdown, enable_above_rising} = 2'h0;
        {breaker_trip, blank_timer_pin_short, current_limit_pin_short} = 3'h0;
        {retry_delay_pin_short, retry_delay_pin_cap} = 2'h0;
        {retry_count_pin_short, retry_count_pin_cap, tied_low} = 3'h0;
        {supply_above_falling, supply_above_rising, present} = 3'h7;
        hs_timeout_cycles = 24'h000028;
        retry_count_measure = 16'h0005;
        err_count = 0;
        tests_run = 0;
        step(8);
        resetn = 1'b1;
        step(3);
        t_handshake();
        t_tied();
        t_latch();
        t_retry(4, 5, 16);
        t_quiet();
        t_otp();
        retry_count_pin_short = 1'b1;
        t_retry(6, 6, 16);
        retry_count_pin_short = 1'b0;
        retry_delay_pin_cap = 1'b1;
        t_retry(4, 5, 256);
        retry_count_pin_cap = 1'b1;
        t_retry(16, 17, 256);
        {retry_count_pin_cap, retry_count_pin_short} = 2'h1;
        t_retry(5, 5, 256);
        give_verdict();
    end
endmodule

`default_nettype wire
